// >>> logic/dpc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants and carriers of the datapath control register block
package dpc_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 16;
    // register map, byte addresses
    localparam logic [ADDR_W-1:0] DATAPATH_CONTROL_OFFSET = 8'h00;
    localparam logic [CTRL_W-1:0] DATAPATH_CONTROL_RESET = 16'h049c;
    // field positions inside the control word
    localparam int BIT_PAIR1_OFFSET = 15;
    localparam int BIT_PAIR2_OFFSET = 14;
    localparam int BIT_PAIR1_PHASE = 13;
    localparam int BIT_PAIR2_PHASE = 12;
    localparam int INTERP_MSB = 11;
    localparam int INTERP_LSB = 8;
    localparam int BIT_FIFO_ENA = 7;
    localparam int BIT_ALARM_OE = 4;
    localparam int BIT_ALARM_POL = 3;
    localparam int BIT_SYNC_ENA = 2;
    localparam int BIT_PAIR1_SINC = 1;
    localparam int BIT_PAIR2_SINC = 0;
    // interpolation select patterns
    localparam logic [3:0] INTERP_1X = 4'h0;
    localparam logic [3:0] INTERP_2X = 4'h1;
    localparam logic [3:0] INTERP_4X = 4'h2;
    localparam logic [3:0] INTERP_8X = 4'h4;
    localparam logic [3:0] INTERP_16X = 4'h8;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // clock divider chain depth, /2 up to /16
    localparam int DIV_STAGES = 4;
    localparam logic [DIV_STAGES-1:0] DIV_CNT_RESET = 4'h0;
    // synchroniser depth for the sync pin
    localparam int SYNC_DEPTH = 3;

    // write channel states, gray along idle, collect, respond
    typedef enum logic [1:0] {
        DPC_WR_IDLE = 2'b00,
        DPC_WR_COLLECT = 2'b01,
        DPC_WR_RESP = 2'b11
    } dpc_wr_state_t;

    // decoded enables handed to the datapath
    typedef struct packed {
        logic pair1_offset_correction_enable;
        logic pair2_offset_correction_enable;
        logic pair1_phase_gain_enable;
        logic pair2_phase_gain_enable;
        logic pair1_sinc_comp_enable;
        logic pair2_sinc_comp_enable;
        logic fifo_enable;
        logic [4:0] interp_ratio;
        logic interp_invalid;
    } dpc_path_cfg_t;

    // whole state of the block
    typedef struct packed {
        dpc_wr_state_t wr_st;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [CTRL_W-1:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [CTRL_W-1:0] rdata;
        logic [1:0] rresp;
        logic [CTRL_W-1:0] ctrl;
        logic [SYNC_DEPTH-1:0] sync_s;
        logic sync_lvl;
        logic [DIV_STAGES-1:0] div_cnt;
        logic [DIV_STAGES-1:0] div_en;
        logic ptr_reset;
        logic alarm_o;
    } dpc_state_t;
endpackage : dpc_pkg

// >>> logic/dpc_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01 - reset loads control word default 0x049c
// RULE_02 - bit 15 enables pair1 offset correction
// RULE_03 - bit 14 enables pair2 offset correction
// RULE_04 - bit 13 enables pair1 phase gain correction
// RULE_05 - bit 12 enables pair2 phase gain correction
// RULE_06 - bits 11:8 one-hot select interpolation ratio
// RULE_07 - interpolation field resets to eight times
// RULE_08 - bit 7 routes samples through fifo
// RULE_09 - without fifo, system aligns both clocks
// RULE_10 - bit 4 drives alarm, else high impedance
// RULE_11 - bit 3 picks alarm polarity, one high
// RULE_12 - bit 2 lets sync pulse resync dividers
// RULE_13 - divided clocks share phase after sync
// RULE_14 - bit 1 enables pair1 inverse sinc
// RULE_15 - bit 0 enables pair2 inverse sinc
// RULE_16 - software keeps reserved bits 6,5 zero
module dpc_ctrl
    import dpc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // datapath configuration
    output dpc_path_cfg_t path_cfg,
    // alarm pin, source level from the datapath
    input wire logic alarm_event,
    output logic alarm_pin_o,
    output logic alarm_pin_oe,
    // sync pin from outside and divider outputs
    input wire logic sync_pin,
    output logic [DIV_STAGES-1:0] div_clk_en,
    output logic fifo_ptr_reset
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // one-hot interpolation pattern to ratio, zero for an illegal pattern
    function automatic logic [4:0] interp_ratio(input logic [3:0] sel);
        logic [4:0] r;
        r = 5'h00;
        case (sel)
            INTERP_1X: r = 5'h01;
            INTERP_2X: r = 5'h02;
            INTERP_4X: r = 5'h04;
            INTERP_8X: r = 5'h08;
            INTERP_16X: r = 5'h10;
            default: r = 5'h00;
        endcase
        return r;
    endfunction : interp_ratio

    // address hits the only register
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        return addr == DATAPATH_CONTROL_OFFSET;
    endfunction : reg_hit

    // byte-lane merge of a write into the control word
    function automatic logic [CTRL_W-1:0] lane_merge(input logic [CTRL_W-1:0] old,
                                                     input logic [CTRL_W-1:0] nw,
                                                     input logic [1:0] strb);
        logic [CTRL_W-1:0] m;
        m = old;
        if (strb[0])
        begin
            m[7:0] = nw[7:0];
        end
        if (strb[1])
        begin
            m[15:8] = nw[15:8];
        end
        return m;
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////////
    // state

    dpc_state_t st_q; // registered state
    dpc_state_t st_d; // next state
    logic aw_fire; // write address taken
    logic w_fire; // write data taken
    logic ar_fire; // read address taken
    logic sync_edge; // agreed rising edge on sync pin
    logic [ADDR_W-1:0] eff_waddr; // address of the completing write
    logic [CTRL_W-1:0] eff_wdata; // data of the completing write
    logic [1:0] eff_wstrb; // lanes of the completing write
    logic wr_complete; // both halves of a write present

    ////////////////////////////////////////////////////////////////////////////
    // handshake outputs, combinational

    assign s_axi_awready = (st_q.wr_st != DPC_WR_RESP) && !st_q.aw_got;
    assign s_axi_wready = (st_q.wr_st != DPC_WR_RESP) && !st_q.w_got;
    assign s_axi_arready = !st_q.rvalid;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;

    // pick held or freshly taken halves of the write
    assign eff_waddr = st_q.aw_got ? st_q.waddr : s_axi_awaddr;
    assign eff_wdata = st_q.w_got ? st_q.wdata : s_axi_wdata[CTRL_W-1:0];
    assign eff_wstrb = st_q.w_got ? st_q.wstrb : s_axi_wstrb[1:0];
    // never complete again while the answer is still pending
    assign wr_complete = (st_q.wr_st != DPC_WR_RESP) && (st_q.aw_got || aw_fire) && (st_q.w_got || w_fire);

    // new high sync level once the last two stages agree
    assign sync_edge = (st_q.sync_s[1] == st_q.sync_s[2]) && st_q.sync_s[2] && !st_q.sync_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic div_run; // running and of the counter bits
        st_d = st_q;
        div_run = 1'b1;
        st_d.ptr_reset = 1'b0;
        // write channel
        case (st_q.wr_st)
            DPC_WR_IDLE, DPC_WR_COLLECT:
            begin
                if (aw_fire)
                begin
                    st_d.aw_got = 1'b1;
                    st_d.waddr = s_axi_awaddr;
                end
                if (w_fire)
                begin
                    st_d.w_got = 1'b1;
                    st_d.wdata = s_axi_wdata[CTRL_W-1:0];
                    st_d.wstrb = s_axi_wstrb[1:0];
                end
                if (wr_complete)
                begin
                    // store and answer
                    st_d.wr_st = DPC_WR_RESP;
                    st_d.bvalid = 1'b1;
                    if (reg_hit(eff_waddr))
                    begin
                        st_d.ctrl = lane_merge(st_q.ctrl, eff_wdata, eff_wstrb); // RULE_02
                        st_d.bresp = RESP_OKAY;
                    end
                    else
                    begin
                        st_d.bresp = RESP_DECERR;
                    end
                end
                else if (aw_fire || w_fire)
                begin
                    st_d.wr_st = DPC_WR_COLLECT;
                end
            end
            DPC_WR_RESP:
            begin
                // hold the answer until taken
                if (s_axi_bready)
                begin
                    st_d.bvalid = 1'b0;
                    st_d.aw_got = 1'b0;
                    st_d.w_got = 1'b0;
                    st_d.wr_st = DPC_WR_IDLE;
                end
            end
            default:
            begin
                st_d.wr_st = DPC_WR_IDLE;
            end
        endcase
        // read channel, answer one cycle after the address
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (ar_fire)
        begin
            st_d.rvalid = 1'b1;
            if (reg_hit(s_axi_araddr))
            begin
                st_d.rdata = st_q.ctrl;
                st_d.rresp = RESP_OKAY;
            end
            else
            begin
                st_d.rdata = 16'h0000;
                st_d.rresp = RESP_DECERR;
            end
        end
        // sync pin synchroniser and agreed level
        st_d.sync_s = {st_q.sync_s[1:0], sync_pin};
        if (st_q.sync_s[1] == st_q.sync_s[2])
        begin
            st_d.sync_lvl = st_q.sync_s[2];
        end
        // free-running divider chain
        st_d.div_cnt = st_q.div_cnt + 4'h1;
        for (int k = 0; k < DIV_STAGES; k++)
        begin
            // stage k fires when all counter bits up to k are set
            div_run = div_run & st_q.div_cnt[k];
            st_d.div_en[k] = div_run;
        end
        // resync restarts every divider from one phase
        if (sync_edge && st_q.ctrl[BIT_SYNC_ENA])
        begin
            st_d.div_cnt = DIV_CNT_RESET; // RULE_12
            st_d.div_en = '0; // RULE_13
            st_d.ptr_reset = 1'b1; // RULE_12
        end
        // alarm polarity
        st_d.alarm_o = st_q.ctrl[BIT_ALARM_POL] ? alarm_event : !alarm_event; // RULE_11
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            st_q.wr_st <= DPC_WR_IDLE;
            st_q.ctrl <= DATAPATH_CONTROL_RESET; // RULE_01 RULE_07
            st_q.alarm_o <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // bus answers from flip-flops
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = {16'h0000, st_q.rdata};

    // datapath enables straight from the control word
    assign path_cfg.pair1_offset_correction_enable = st_q.ctrl[BIT_PAIR1_OFFSET]; // RULE_02
    assign path_cfg.pair2_offset_correction_enable = st_q.ctrl[BIT_PAIR2_OFFSET]; // RULE_03
    assign path_cfg.pair1_phase_gain_enable = st_q.ctrl[BIT_PAIR1_PHASE]; // RULE_04
    assign path_cfg.pair2_phase_gain_enable = st_q.ctrl[BIT_PAIR2_PHASE]; // RULE_05
    assign path_cfg.pair1_sinc_comp_enable = st_q.ctrl[BIT_PAIR1_SINC]; // RULE_14
    assign path_cfg.pair2_sinc_comp_enable = st_q.ctrl[BIT_PAIR2_SINC]; // RULE_15
    assign path_cfg.fifo_enable = st_q.ctrl[BIT_FIFO_ENA]; // RULE_08
    assign path_cfg.interp_ratio = interp_ratio(st_q.ctrl[INTERP_MSB:INTERP_LSB]); // RULE_06
    assign path_cfg.interp_invalid = (interp_ratio(st_q.ctrl[INTERP_MSB:INTERP_LSB]) == 5'h00);

    // alarm pin drive
    assign alarm_pin_o = st_q.alarm_o;
    assign alarm_pin_oe = st_q.ctrl[BIT_ALARM_OE]; // RULE_10

    // divider enables and pointer reset
    assign div_clk_en = st_q.div_en;
    assign fifo_ptr_reset = st_q.ptr_reset;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking dpc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // control word after reset, interpolation at eight
    a_reset_default: assert property ($rose(aresetn) |-> st_q.ctrl == DATAPATH_CONTROL_RESET) // RULE_01
        else $error("control word not at default after reset");
    a_reset_interp: assert property ($rose(aresetn) |-> path_cfg.interp_ratio == 5'h08) // RULE_07
        else $error("interpolation not eight after reset");
    // write to register lands one edge later
    a_write_lands: assert property (wr_complete && reg_hit(eff_waddr) && (eff_wstrb == 2'h3) // RULE_02
        |=> path_cfg.pair1_offset_correction_enable == $past(eff_wdata[BIT_PAIR1_OFFSET]))
        else $error("offset enable did not follow write");
    a_cd_offset: assert property (path_cfg.pair2_offset_correction_enable == st_q.ctrl[BIT_PAIR2_OFFSET] // RULE_03
        && path_cfg.pair1_phase_gain_enable == st_q.ctrl[BIT_PAIR1_PHASE])
        else $error("correction enables mismatch");
    a_cd_phase: assert property (path_cfg.pair2_phase_gain_enable == st_q.ctrl[BIT_PAIR2_PHASE]) // RULE_05
        else $error("pair2 phase gain mismatch");
    a_sinc_map: assert property (path_cfg.pair1_sinc_comp_enable == st_q.ctrl[BIT_PAIR1_SINC] // RULE_14
        && path_cfg.pair2_sinc_comp_enable == st_q.ctrl[BIT_PAIR2_SINC])
        else $error("inverse sinc enables mismatch");
    a_interp_16: assert property (st_q.ctrl[INTERP_MSB:INTERP_LSB] == INTERP_16X // RULE_06
        |-> path_cfg.interp_ratio == 5'h10 && !path_cfg.interp_invalid)
        else $error("sixteen times not decoded");
    a_alarm_pol: assert property (st_q.ctrl[BIT_ALARM_POL] && $stable(st_q.ctrl) // RULE_11
        |=> alarm_pin_o == $past(alarm_event))
        else $error("alarm polarity wrong");
    a_alarm_hiz: assert property (!st_q.ctrl[BIT_ALARM_OE] |-> !alarm_pin_oe) // RULE_10
        else $error("alarm driven while disabled");
    // counter restarts at zero, stage 0 fires on the third cycle, stage 1 on the fifth
    a_resync_phase: assert property (sync_edge && st_q.ctrl[BIT_SYNC_ENA] // RULE_13
        |=> fifo_ptr_reset && div_clk_en == 4'h0 ##1 div_clk_en == 4'h0 ##1 div_clk_en == 4'h1
        ##1 div_clk_en == 4'h0 ##1 div_clk_en == 4'h3)
        else $error("dividers not realigned after sync");
    a_no_resync: assert property (sync_edge && !st_q.ctrl[BIT_SYNC_ENA] |=> !fifo_ptr_reset) // RULE_12
        else $error("resync while disabled");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");

    // main scenarios
    c_write_reg: cover property (wr_complete && reg_hit(eff_waddr));
    c_resync: cover property (sync_edge && st_q.ctrl[BIT_SYNC_ENA]);
    c_read_bad: cover property (ar_fire && !reg_hit(s_axi_araddr));
    c_fifo_off: cover property (!path_cfg.fifo_enable);

endmodule : dpc_ctrl

// >>> sim/dpc_ctrl_tb_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// one comparison, counted, mismatch reported at once
`define chk(name, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            $display("MISMATCH %s expected %h seen %h", name, exp, got); \
            mismatches++; \
        end \
    end
module dpc_ctrl_tb_top
    import dpc_pkg::*;
;
    // clock and reset
    logic aclk;
    logic aresetn;
    // axi4-lite master side
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    // datapath side
    dpc_path_cfg_t path_cfg;
    logic alarm_event, alarm_pin_o, alarm_pin_oe, sync_pin, fifo_ptr_reset;
    logic [DIV_STAGES-1:0] div_clk_en;
    // bookkeeping
    int mismatches = 0;
    int num_checks = 0;
    logic [DATA_W-1:0] rd_q;
    logic [1:0] resp_q;
    int cnt[DIV_STAGES];
    int pulses;
    // control words walked through the register
    logic [CTRL_W-1:0] words[7] = '{16'h0000, 16'h8100, 16'h4200, 16'h2400, 16'h1800, 16'h0302, 16'h0081};

    dpc_ctrl uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .path_cfg(path_cfg), .alarm_event(alarm_event), .alarm_pin_o(alarm_pin_o),
        .alarm_pin_oe(alarm_pin_oe), .sync_pin(sync_pin), .div_clk_en(div_clk_en),
        .fifo_ptr_reset(fifo_ptr_reset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // 4 ns clock
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // expected enables for a control word
    function automatic dpc_path_cfg_t cfg_of(input logic [CTRL_W-1:0] w);
        dpc_path_cfg_t c;
        c.pair1_offset_correction_enable = w[15];
        c.pair2_offset_correction_enable = w[14];
        c.pair1_phase_gain_enable = w[13];
        c.pair2_phase_gain_enable = w[12];
        c.pair1_sinc_comp_enable = w[1];
        c.pair2_sinc_comp_enable = w[0];
        c.fifo_enable = w[7];
        case (w[11:8])
            4'h0: c.interp_ratio = 5'h01;
            4'h1: c.interp_ratio = 5'h02;
            4'h2: c.interp_ratio = 5'h04;
            4'h4: c.interp_ratio = 5'h08;
            4'h8: c.interp_ratio = 5'h10;
            default: c.interp_ratio = 5'h00;
        endcase
        c.interp_invalid = (c.interp_ratio == 5'h00);
        return c;
    endfunction : cfg_of

    // one write: address and data offered together, each released when taken
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                resp_q = bresp;
                done = 1'b1;
            end
        end
    endtask : axi_write

    // one read, response kept in rd_q and resp_q
    task automatic axi_read(input logic [ADDR_W-1:0] a);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rd_q = rdata;
                resp_q = rresp;
                done = 1'b1;
            end
        end
    endtask : axi_read

    // write the control word, expect okay
    task automatic put(input logic [CTRL_W-1:0] w);
        axi_write(DATAPATH_CONTROL_OFFSET, {16'h0000, w}, 4'hf);
        `chk("bresp", RESP_OKAY, resp_q)
    endtask : put

    // read the control word back and check it
    task automatic expect_word(input logic [CTRL_W-1:0] w);
        axi_read(DATAPATH_CONTROL_OFFSET);
        `chk("rdata", {16'h0000, w}, rd_q)
        `chk("rresp", RESP_OKAY, resp_q)
        `chk("path_cfg", cfg_of(w), path_cfg)
    endtask : expect_word

    // verdict, the single end of the run
    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, alarm_event, sync_pin} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // defaults after reset
        `chk("oe_reset", 1'b1, alarm_pin_oe)
        expect_word(DATAPATH_CONTROL_RESET);
        `chk("interp_reset", 5'h08, path_cfg.interp_ratio)
        `chk("fifo_reset", 1'b1, path_cfg.fifo_enable)
        // enables and every interpolation pattern, one illegal
        foreach (words[i])
        begin
            put(words[i]);
            expect_word(words[i]);
        end
        // byte lane 0 only, upper data ignored
        put(16'h0000);
        axi_write(DATAPATH_CONTROL_OFFSET, 32'hffff_ff9f, 4'h1);
        expect_word(16'h009f);
        // unmapped place refused, register untouched
        axi_write(8'h04, 32'h0000_8000, 4'hf);
        `chk("bresp_unmapped", RESP_DECERR, resp_q)
        axi_read(8'h04);
        `chk("rresp_unmapped", RESP_DECERR, resp_q)
        `chk("rdata_unmapped", 32'h0000_0000, rd_q)
        expect_word(16'h009f);
        // alarm drive and polarity
        put(16'h0000);
        `chk("oe_off", 1'b0, alarm_pin_oe)
        put(16'h0018);
        `chk("oe_on", 1'b1, alarm_pin_oe)
        alarm_event <= 1'b1;
        repeat (3) @(posedge aclk);
        `chk("alarm_high_pos", 1'b1, alarm_pin_o)
        put(16'h0010);
        repeat (2) @(posedge aclk);
        `chk("alarm_high_neg", 1'b0, alarm_pin_o)
        alarm_event <= 1'b0;
        repeat (3) @(posedge aclk);
        `chk("alarm_idle_neg", 1'b1, alarm_pin_o)
        // sync pulse ignored while resync disabled
        pulses = 0;
        sync_pin <= 1'b1;
        repeat (12)
        begin
            @(posedge aclk);
            pulses += fifo_ptr_reset;
        end
        `chk("sync_disabled", 0, pulses)
        sync_pin <= 1'b0;
        put(16'h0004);
        repeat (6) @(posedge aclk);
        // sync pulse accepted while enabled
        sync_pin <= 1'b1;
        repeat (12)
        begin
            @(posedge aclk);
            if (fifo_ptr_reset === 1'b1 && pulses == 0)
            begin
                pulses = 1;
                `chk("div_at_sync", 4'h0, div_clk_en)
                cnt = '{default: 0};
                repeat (32)
                begin
                    @(posedge aclk);
                    `chk("ptr_reset_single", 1'b0, fifo_ptr_reset)
                    `chk("div_nested", 1'b1, div_clk_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
                    for (int k = 0; k < DIV_STAGES; k++)
                        cnt[k] += div_clk_en[k];
                end
            end
        end
        `chk("sync_pulse", 1, pulses)
        for (int k = 0; k < DIV_STAGES; k++)
            `chk("div_count", 32 >> (k + 1), cnt[k])
        report_and_stop();
    end
endmodule : dpc_ctrl_tb_top
